// [design/dit_axil.sv]
// AXI4-Lite slave that turns bus transfers into register accesses
`timescale 1ns/10ps
module dit_axil
  import dit_pkg::*;
#(
  parameter int ADDR_W = 12
) (
  input  wire logic              clk_sys,
  input  wire logic              resetn,
  input  wire logic [ADDR_W-1:0] awaddr,
  input  wire logic              awvalid,
  output logic                   awready,
  input  wire logic [31:0]       wdata,
  input  wire logic [3:0]        wstrb,
  input  wire logic              wvalid,
  output logic                   wready,
  output logic [1:0]             bresp,
  output logic                   bvalid,
  input  wire logic              bready,
  input  wire logic [ADDR_W-1:0] araddr,
  input  wire logic              arvalid,
  output logic                   arready,
  output logic [31:0]            rdata,
  output logic [1:0]             rresp,
  output logic                   rvalid,
  input  wire logic              rready,
  dit_reg_if.slave               r
);

  if (ADDR_W < IDX_W + 2) begin : g_chk
    $error("dit_axil: ADDR_W too small for the register map");
  end

  dit_wr_state_t     wrState, next_wrState;
  logic              awHeld, next_awHeld, wHeld, next_wHeld;
  logic [IDX_W-1:0]  awIdx, next_awIdx;
  logic [7:0]        wByte, next_wByte;
  logic              wLane, next_wLane;
  logic              next_awready, next_wready, next_bvalid, next_arready, next_rvalid;
  logic [1:0]        next_bresp, next_rresp;
  logic [31:0]       next_rdata;
  logic              wrFire;

  ////////////////////////////////////////////////////////////////////////////////
  // Register side: write fires once both halves are held
  assign wrFire   = (wrState == WR_COLLECT) & awHeld & wHeld;
  assign r.wrEn   = wrFire & wLane;
  assign r.wrIdx  = awIdx;
  assign r.wrData = wByte;
  assign r.rdIdx  = araddr[IDX_W+1:2];

  // Next values of both channels
  always_comb
  begin
    next_wrState = wrState;
    next_awHeld  = awHeld;
    next_wHeld   = wHeld;
    next_awIdx   = awIdx;
    next_wByte   = wByte;
    next_wLane   = wLane;
    next_bvalid  = bvalid;
    next_bresp   = bresp;
    next_rvalid  = rvalid;
    next_rresp   = rresp;
    next_rdata   = rdata;
    if (awvalid && awready)
    begin
      next_awHeld = 1'b1;
      next_awIdx  = awaddr[IDX_W+1:2];
    end
    if (wvalid && wready)
    begin
      next_wHeld = 1'b1;
      next_wByte = wdata[7:0];
      next_wLane = wstrb[0];
    end
    case (wrState)
      WR_COLLECT:
        if (wrFire)
        begin
          next_bvalid  = 1'b1;
          next_bresp   = r.wrOk ? RESP_OKAY : RESP_SLVERR;
          next_awHeld  = 1'b0;
          next_wHeld   = 1'b0;
          next_wrState = WR_RESP;
        end
      WR_RESP:
        if (bready)
        begin
          next_bvalid  = 1'b0;
          next_wrState = WR_COLLECT;
        end
      default:
        next_wrState = WR_COLLECT;
    endcase
    if (arvalid && arready)
    begin
      next_rvalid = 1'b1;
      next_rresp  = r.rdOk ? RESP_OKAY : RESP_SLVERR;
      next_rdata  = {24'h000000, r.rdOk ? r.rdData : 8'h00};
    end
    else if (rvalid && rready)
      next_rvalid = 1'b0;
    next_awready = (next_wrState == WR_COLLECT) & ~next_awHeld;
    next_wready  = (next_wrState == WR_COLLECT) & ~next_wHeld;
    next_arready = ~next_rvalid;
  end

  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      wrState <= WR_COLLECT;
      awHeld  <= 1'b0;
      wHeld   <= 1'b0;
      awIdx   <= '0;
      wByte   <= 8'h00;
      wLane   <= 1'b0;
      awready <= 1'b0;
      wready  <= 1'b0;
      bvalid  <= 1'b0;
      bresp   <= RESP_OKAY;
      arready <= 1'b0;
      rvalid  <= 1'b0;
      rresp   <= RESP_OKAY;
      rdata   <= 32'h00000000;
    end
    else
    begin
      wrState <= next_wrState;
      awHeld  <= next_awHeld;
      wHeld   <= next_wHeld;
      awIdx   <= next_awIdx;
      wByte   <= next_wByte;
      wLane   <= next_wLane;
      awready <= next_awready;
      wready  <= next_wready;
      bvalid  <= next_bvalid;
      bresp   <= next_bresp;
      arready <= next_arready;
      rvalid  <= next_rvalid;
      rresp   <= next_rresp;
      rdata   <= next_rdata;
    end
  end

endmodule : dit_axil

// [design/dit_if.sv]
// Interfaces between the timer top, its counters and its bus slave
`timescale 1ns/10ps

////////////////////////////////////////////////////////////////////////////////
// One 8-bit counter with its compare value and match pulse
interface dit_timer_if #(parameter int W = 8);
  logic         run;
  logic         tick;
  logic [W-1:0] compare;
  logic         match;
  modport timer (input run, input tick, input compare, output match);
  modport ctrl  (output run, output tick, output compare, input match);
endinterface : dit_timer_if

////////////////////////////////////////////////////////////////////////////////
// Register access decoded from the bus
interface dit_reg_if #(parameter int IW = 10);
  logic          wrEn;
  logic [IW-1:0] wrIdx;
  logic [7:0]    wrData;
  logic          wrOk;
  logic [IW-1:0] rdIdx;
  logic [7:0]    rdData;
  logic          rdOk;
  modport slave (output wrEn, output wrIdx, output wrData, output rdIdx,
                 input wrOk, input rdData, input rdOk);
  modport regs  (input wrEn, input wrIdx, input wrData, input rdIdx,
                 output wrOk, output rdData, output rdOk);
endinterface : dit_reg_if

// [design/dit_pkg.sv]
// Constants, register map and types of the dual interval timer block
package dit_pkg;

  // Register index width; the byte address is four times the index
  localparam int IDX_W = 10;

  // Register indices
  localparam logic [IDX_W-1:0] IDX_RUN  [0:1] = '{10'h100, 10'h108};
  localparam logic [IDX_W-1:0] IDX_MODE [0:1] = '{10'h104, 10'h10C};
  localparam logic [IDX_W-1:0] IDX_FFCR [0:1] = '{10'h105, 10'h10D};
  localparam logic [IDX_W-1:0] IDX_CMP  [0:3] = '{10'h102, 10'h103, 10'h10A, 10'h10B};
  localparam logic [IDX_W-1:0] IDX_IRQ_STAT = 10'h110;
  localparam logic [IDX_W-1:0] IDX_IRQ_CLR  = 10'h111;
  localparam logic [IDX_W-1:0] IDX_IRQ_EN   = 10'h112;
  localparam logic [IDX_W-1:0] IDX_STATE    = 10'h113;

  // Flip-flop control fields and reset value
  localparam int         FF_CMD_LSB = 2;
  localparam int         FF_IE_BIT  = 1;
  localparam int         FF_IS_BIT  = 0;
  localparam logic [7:0] FFCR_RESET = 8'h0C;

  // Flip-flop commands
  localparam logic [1:0] CMD_INVERT = 2'h0;
  localparam logic [1:0] CMD_SET    = 2'h1;
  localparam logic [1:0] CMD_CLEAR  = 2'h2;
  localparam logic [1:0] CMD_KEEP   = 2'h3;

  // Mode register fields and reset value
  localparam int         MODE_OP_LSB   = 6;
  localparam int         MODE_UCLK_LSB = 2;
  localparam int         MODE_LCLK_LSB = 0;
  localparam logic [7:0] MODE_RESET    = 8'h00;
  localparam logic [1:0] MODE_8BIT     = 2'h0;

  // Run register fields and reset value
  localparam int         RUN_LOWER_BIT = 0;
  localparam int         RUN_UPPER_BIT = 1;
  localparam logic [1:0] RUN_RESET     = 2'h0;

  // Prescaler width and tap masks for the four tick rates
  localparam int              PRE_W = 12;
  localparam logic [PRE_W-1:0] TAP_MASK [0:3] = '{12'h007, 12'h01F, 12'h07F, 12'h7FF};

  // Bus answers
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Write path states of the bus slave
  typedef enum logic [1:0] {
    WR_COLLECT = 2'b01,
    WR_RESP    = 2'b10
  } dit_wr_state_t;

endpackage : dit_pkg

// [design/dit_timer8.sv]
// One interval counter with compare match and clear
`timescale 1ns/10ps
module dit_timer8
  import dit_pkg::*;
#(
  parameter int W = 8
) (
  input  wire logic clk_sys,
  input  wire logic resetn,
  dit_timer_if.timer t
);

  logic [W-1:0] count;
  logic [W-1:0] next_count;
  logic [W-1:0] incCount;

  ////////////////////////////////////////////////////////////////////////////////
  // Match on the tick that brings the counter to the compare value; zero matches on wrap
  assign incCount = count + 1'b1;
  assign t.match  = t.run & t.tick & (incCount == t.compare);

  // Stopped counter is held at zero, a match clears it
  always_comb
  begin
    next_count = count;
    if (!t.run)
      next_count = '0;
    else if (t.match)
      next_count = '0;
    else if (t.tick)
      next_count = incCount;
  end

  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
      count <= '0;
    else
      count <= next_count;
  end

endmodule : dit_timer8

// [design/dit_top.sv]
// Two pairs of 8-bit interval timers with output flip-flops, interrupts and AXI4-Lite registers
//
// Behaviour
// - Each timer of a pair counts, compares and interrupts on its own as an 8-bit interval timer.
// - A flip-flop control write with command 00 inverts the output flip-flop, 01 sets it, 10 clears it, 11 keeps it.
// - With toggle enable at 0 matches leave the output flip-flop alone; at 1 the selected match inverts it.
// - Toggle source 0 picks the lower timer's match and 1 the upper's, and only in 8-bit timer mode.
// - When a counter reaches its compare value it clears to zero and raises that timer's interrupt.
// - A compare value of zero matches when the counter overflows.
// - A cleared run bit stops and zeroes its counter, a set one resumes, and reset leaves all stopped.
//
// The implementer's own choice: the AXI4-Lite slave port.
`timescale 1ns/10ps
module dit_top
  import dit_pkg::*;
#(
  parameter int ADDR_W = 12
) (
  input  wire logic              clk_sys,
  input  wire logic              resetn,
  input  wire logic [ADDR_W-1:0] awaddr,
  input  wire logic              awvalid,
  output logic                   awready,
  input  wire logic [31:0]       wdata,
  input  wire logic [3:0]        wstrb,
  input  wire logic              wvalid,
  output logic                   wready,
  output logic [1:0]             bresp,
  output logic                   bvalid,
  input  wire logic              bready,
  input  wire logic [ADDR_W-1:0] araddr,
  input  wire logic              arvalid,
  output logic                   arready,
  output logic [31:0]            rdata,
  output logic [1:0]             rresp,
  output logic                   rvalid,
  input  wire logic              rready,
  input  wire logic              extClkA,
  input  wire logic              extClkB,
  output logic                   pairAOutputToggle,
  output logic                   pairBOutputToggle,
  output logic                   irq
);

  dit_reg_if #(.IW(IDX_W)) rb ();
  dit_timer_if #(.W(8))    tmr [4] ();

  // Per-pair control state
  logic [7:0]       mode      [2];
  logic [7:0]       next_mode [2];
  logic [1:0]       next_run [2];
  logic [1:0]       runR [2];
  logic [1:0]       toggleEn, next_toggleEn;
  logic [1:0]       toggleSrc, next_toggleSrc;
  logic [1:0]       ffCmd [2];
  logic [1:0]       next_ffCmd [2];
  logic [1:0]       ffState, next_ffState;
  logic [3:0]       irqStat, next_irqStat;
  logic [3:0]       irqEn, next_irqEn;
  logic             next_irq;
  logic [7:0]       cmp [4];
  logic [PRE_W-1:0] pre, next_pre;
  logic [3:0]       tap;
  logic [1:0]       extSync1, extSync2, extSync3;
  logic [1:0]       extEdge;
  logic [3:0]       match;
  logic [3:0]       tick;
  logic             anyRun;

  ////////////////////////////////////////////////////////////////////////////////
  // Bus slave
  dit_axil #(.ADDR_W(ADDR_W)) u_axil (
    .clk_sys (clk_sys),
    .resetn  (resetn),
    .awaddr  (awaddr),
    .awvalid (awvalid),
    .awready (awready),
    .wdata   (wdata),
    .wstrb   (wstrb),
    .wvalid  (wvalid),
    .wready  (wready),
    .bresp   (bresp),
    .bvalid  (bvalid),
    .bready  (bready),
    .araddr  (araddr),
    .arvalid (arvalid),
    .arready (arready),
    .rdata   (rdata),
    .rresp   (rresp),
    .rvalid  (rvalid),
    .rready  (rready),
    .r       (rb.slave)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // External count inputs: two-flop synchroniser, then rising-edge detect on later stages
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      extSync1 <= 2'h0;
      extSync2 <= 2'h0;
      extSync3 <= 2'h0;
    end
    else
    begin
      extSync1 <= {extClkB, extClkA};
      extSync2 <= extSync1;
      extSync3 <= extSync2;
    end
  end

  assign extEdge = extSync2 & ~extSync3;

  ////////////////////////////////////////////////////////////////////////////////
  // Shared prescaler: runs while any timer runs, cleared when all stop
  assign anyRun = |{runR[1], runR[0]};

  always_comb
  begin
    next_pre = anyRun ? pre + 1'b1 : '0;
  end

  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
      pre <= '0;
    else
      pre <= next_pre;
  end

  // Tick taps at four rates
  for (genvar k = 0; k < 4; k++) begin : g_tap
    assign tap[k] = anyRun & ((pre & TAP_MASK[k]) == TAP_MASK[k]);
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Four counters; lower and upper of each pair run independently
  for (genvar i = 0; i < 4; i++) begin : g_tmr
    assign tmr[i].run     = runR[i/2][i%2];
    assign tmr[i].tick    = tick[i];
    assign tmr[i].compare = cmp[i];
    assign match[i]       = tmr[i].match;
    dit_timer8 #(.W(8)) u_tmr (
      .clk_sys (clk_sys),
      .resetn  (resetn),
      .t       (tmr[i].timer)
    );
  end

  // Count clock selection per counter
  always_comb
  begin
    tick = 4'h0;
    for (int p = 0; p < 2; p++)
    begin
      case (mode[p][MODE_LCLK_LSB +: 2])
        2'h0:    tick[2*p] = extEdge[p];
        2'h1:    tick[2*p] = tap[0];
        2'h2:    tick[2*p] = tap[1];
        default: tick[2*p] = tap[2];
      endcase
      case (mode[p][MODE_UCLK_LSB +: 2])
        2'h0:    tick[2*p+1] = match[2*p];
        2'h1:    tick[2*p+1] = tap[0];
        2'h2:    tick[2*p+1] = tap[2];
        default: tick[2*p+1] = tap[3];
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Compare registers: write-only and deliberately without reset
  always_ff @(posedge clk_sys)
  begin
    for (int i = 0; i < 4; i++)
      if (rb.wrEn && rb.wrIdx == IDX_CMP[i])
        cmp[i] <= rb.wrData;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Control registers, output flip-flops and interrupt status: next values
  always_comb
  begin
    logic hwToggle;
    logic pairMatch;
    hwToggle       = 1'b0;
    pairMatch      = 1'b0;
    next_mode      = mode;
    next_run       = runR;
    next_toggleEn  = toggleEn;
    next_toggleSrc = toggleSrc;
    next_ffState   = ffState;
    for (int p = 0; p < 2; p++)
    begin
      next_ffCmd[p] = CMD_KEEP;
      if (rb.wrEn && rb.wrIdx == IDX_MODE[p])
        next_mode[p] = rb.wrData;
      if (rb.wrEn && rb.wrIdx == IDX_RUN[p])
        next_run[p] = rb.wrData[1:0];
      if (rb.wrEn && rb.wrIdx == IDX_FFCR[p])
      begin
        next_ffCmd[p]     = rb.wrData[FF_CMD_LSB +: 2];
        next_toggleEn[p]  = rb.wrData[FF_IE_BIT];
        next_toggleSrc[p] = rb.wrData[FF_IS_BIT];
      end
      pairMatch = toggleSrc[p] ? match[2*p+1] : match[2*p];
      hwToggle  = toggleEn[p] & pairMatch & (mode[p][MODE_OP_LSB +: 2] == MODE_8BIT);
      // Software command wins over a hardware toggle in the same cycle
      case (ffCmd[p])
        CMD_INVERT: next_ffState[p] = ~ffState[p];
        CMD_SET:    next_ffState[p] = 1'b1;
        CMD_CLEAR:  next_ffState[p] = 1'b0;
        default:    next_ffState[p] = hwToggle ? ~ffState[p] : ffState[p];
      endcase
    end
    next_irqEn = irqEn;
    if (rb.wrEn && rb.wrIdx == IDX_IRQ_EN)
      next_irqEn = rb.wrData[3:0];
    // A match in the clearing cycle survives the clear
    next_irqStat = irqStat;
    if (rb.wrEn && rb.wrIdx == IDX_IRQ_CLR)
      next_irqStat = irqStat & ~rb.wrData[3:0];
    next_irqStat = next_irqStat | match;
    next_irq     = |(next_irqStat & next_irqEn);
  end

  // Control registers: state
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      for (int p = 0; p < 2; p++)
      begin
        mode[p]  <= MODE_RESET;
        runR[p]  <= RUN_RESET;
        ffCmd[p] <= FFCR_RESET[FF_CMD_LSB +: 2];
      end
      toggleEn  <= {2{FFCR_RESET[FF_IE_BIT]}};
      toggleSrc <= {2{FFCR_RESET[FF_IS_BIT]}};
      ffState   <= 2'h0;
      irqStat   <= 4'h0;
      irqEn     <= 4'h0;
      irq       <= 1'b0;
    end
    else
    begin
      mode      <= next_mode;
      runR      <= next_run;
      ffCmd     <= next_ffCmd;
      toggleEn  <= next_toggleEn;
      toggleSrc <= next_toggleSrc;
      ffState   <= next_ffState;
      irqStat   <= next_irqStat;
      irqEn     <= next_irqEn;
      irq       <= next_irq;
    end
  end

  // Timer outputs straight from the flip-flops
  assign pairAOutputToggle = ffState[0];
  assign pairBOutputToggle = ffState[1];

  ////////////////////////////////////////////////////////////////////////////////
  // Register read mux and address decode; write-only registers read as zero
  always_comb
  begin
    rb.rdData = 8'h00;
    rb.rdOk   = 1'b1;
    case (rb.rdIdx)
      IDX_RUN[0]:   rb.rdData = {6'h00, runR[0]};
      IDX_RUN[1]:   rb.rdData = {6'h00, runR[1]};
      IDX_MODE[0]:  rb.rdData = mode[0];
      IDX_MODE[1]:  rb.rdData = mode[1];
      IDX_IRQ_STAT: rb.rdData = {4'h0, irqStat};
      IDX_IRQ_EN:   rb.rdData = {4'h0, irqEn};
      IDX_STATE:    rb.rdData = {6'h00, ffState};
      IDX_CMP[0], IDX_CMP[1], IDX_CMP[2], IDX_CMP[3],
      IDX_FFCR[0], IDX_FFCR[1], IDX_IRQ_CLR:
        rb.rdData = 8'h00;
      default:      rb.rdOk = 1'b0;
    endcase
  end

  // Write decode: every mapped index answers OKAY
  always_comb
  begin
    case (rb.wrIdx)
      IDX_RUN[0], IDX_RUN[1], IDX_MODE[0], IDX_MODE[1], IDX_FFCR[0], IDX_FFCR[1],
      IDX_CMP[0], IDX_CMP[1], IDX_CMP[2], IDX_CMP[3],
      IDX_IRQ_STAT, IDX_IRQ_CLR, IDX_IRQ_EN, IDX_STATE:
        rb.wrOk = 1'b1;
      default:
        rb.wrOk = 1'b0;
    endcase
  end

  // Software sequencing (stop before reconfiguring) is left to the driver
  // counters read compare and mode live, so a running reprogram takes effect mid-count

endmodule : dit_top

// [dv/dit_monitor.sv]
// Port checks of the dual interval timer
`timescale 1ns/10ps
////////////////////////////////////////////////////////////////////////////////
module dit_monitor (
  input wire logic        clk_sys,
  input wire logic        resetn,
  input wire logic        awvalid,
  input wire logic        awready,
  input wire logic        wvalid,
  input wire logic        wready,
  input wire logic [1:0]  bresp,
  input wire logic        bvalid,
  input wire logic        bready,
  input wire logic        arvalid,
  input wire logic        arready,
  input wire logic [31:0] rdata,
  input wire logic        rvalid,
  input wire logic        rready,
  input wire logic        pairAOutputToggle,
  input wire logic        pairBOutputToggle,
  input wire logic        irq
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  // Bus answers and holding
  a_write_answer: assert property (awvalid && awready && wvalid && wready |-> ##2 bvalid)
    else $error("write answer late");
  a_bresp_hold: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write answer dropped");
  a_bresp_done: assert property (bvalid && bready |=> !bvalid)
    else $error("write answer repeated");
  a_read_answer: assert property (arvalid && arready |=> rvalid)
    else $error("read answer late");
  a_rdata_hold: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("read answer dropped");
  a_rdata_byte: assert property (rvalid |-> rdata[31:8] == 24'h0)
    else $error("read upper bytes set");
  a_write_block: assert property (bvalid |-> !awready && !wready)
    else $error("second write accepted");
  a_read_block: assert property (rvalid |-> !arready)
    else $error("second read accepted");
  // Quiet outputs straight after reset, all readies raised one cycle later
  a_reset_quiet: assert property ($rose(resetn) |-> !irq && !pairAOutputToggle && !pairBOutputToggle)
    else $error("outputs not cleared by reset");
  a_ready_back: assert property ($rose(resetn) |=> awready && wready && arready)
    else $error("ready not raised after reset");
endmodule : dit_monitor

bind dit_top dit_monitor u_mon (
  .clk_sys(clk_sys), .resetn(resetn), .awvalid(awvalid), .awready(awready), .wvalid(wvalid),
  .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .arvalid(arvalid),
  .arready(arready), .rdata(rdata), .rvalid(rvalid), .rready(rready),
  .pairAOutputToggle(pairAOutputToggle), .pairBOutputToggle(pairBOutputToggle), .irq(irq)
);

// [dv/tb_dual_8bit_interval_timer.sv]
// Self-checking bench of the dual interval timer
`timescale 1ns/10ps
`define CHK(n, e, a) begin samples_checked++; if ((a) !== (e)) begin err_total++; \
  $display("ERROR %s expected %h seen %h", n, e, a); end end
////////////////////////////////////////////////////////////////////////////////
module tb_dual_8bit_interval_timer;
  import dit_pkg::*;
  logic        clk_sys, resetn, awvalid, wvalid, bready, arvalid, rready;
  logic        awready, wready, bvalid, arready, rvalid, irq, o0, extB;
  logic        pairAOutputToggle, pairBOutputToggle;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rd;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp;
  int          err_total, samples_checked, k;
  localparam logic [7:0] CFG  [0:3] = '{8'h0C, 8'h0C, 8'h0D, 8'h0E};
  localparam logic [1:0] CMDS [0:4] = '{CMD_SET, CMD_CLEAR, CMD_INVERT, CMD_INVERT, CMD_KEEP};
  localparam logic [3:0] TOG  = 4'h8;
  localparam logic [4:0] FFX  = 5'h05;

  dit_top u_dut (
    .clk_sys(clk_sys), .resetn(resetn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
    .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
    .rresp(rresp), .rvalid(rvalid), .rready(rready), .extClkA(1'h0), .extClkB(extB),
    .pairAOutputToggle(pairAOutputToggle), .pairBOutputToggle(pairBOutputToggle), .irq(irq)
  );

  // Clock
  initial
  begin
    clk_sys = 1'h0;
    forever #12.5 clk_sys = ~clk_sys;
  end

  // Bus write, checking the answer code
  task automatic wr(input logic [9:0] i, input logic [7:0] d, input logic [1:0] er = RESP_OKAY);
    int n;
    n = 0;
    @(posedge clk_sys);
    awaddr  <= {i, 2'h0};
    wdata   <= {24'h0, d};
    awvalid <= 1'h1;
    wvalid  <= 1'h1;
    bready  <= 1'h1;
    do
    begin
      @(posedge clk_sys);
      if (awready) awvalid <= 1'h0;
      if (wready) wvalid <= 1'h0;
      n++;
    end while (!bvalid && n < 50);
    bready <= 1'h0;
    `CHK("bvalid", 1'h1, bvalid)
    `CHK("bresp", er, bresp)
  endtask : wr

  // Bus read, checking the answer code
  task automatic rd_reg(input logic [9:0] i, output logic [31:0] d, input logic [1:0] er = RESP_OKAY);
    int n;
    n = 0;
    @(posedge clk_sys);
    araddr  <= {i, 2'h0};
    arvalid <= 1'h1;
    rready  <= 1'h1;
    do
    begin
      @(posedge clk_sys);
      if (arready) arvalid <= 1'h0;
      n++;
    end while (!rvalid && n < 50);
    rready <= 1'h0;
    d = rdata;
    `CHK("rvalid", 1'h1, rvalid)
    `CHK("rresp", er, rresp)
  endtask : rd_reg

  // Bounded wait for an interrupt level
  task automatic wait_irq(input int lim, input logic e);
    int n;
    n = 0;
    do
    begin
      @(posedge clk_sys);
      n++;
    end while (irq !== e && n < lim);
    `CHK("irq", e, irq)
  endtask : wait_irq

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : report_and_stop

  // Watchdog
  initial
  begin
    repeat (20000) @(posedge clk_sys);
    err_total++;
    report_and_stop();
  end

  // Tests
  initial
  begin
    {resetn, awvalid, wvalid, bready, arvalid, rready, extB} = 7'h00;
    {awaddr, araddr, wdata} = 56'h0;
    wstrb = 4'hF;
    repeat (4) @(posedge clk_sys);
    resetn <= 1'h1;
    repeat (2) @(posedge clk_sys);
    rd_reg(IDX_IRQ_STAT, rd); `CHK("status", 32'h0, rd)
    rd_reg(IDX_STATE, rd); `CHK("state", 32'h0, rd)
    rd_reg(IDX_CMP[2], rd); `CHK("compare", 32'h0, rd)
    rd_reg(IDX_FFCR[1], rd); `CHK("ffctl", 32'h0, rd)
    wr(10'h3FF, 8'hAA, RESP_SLVERR);
    rd_reg(10'h3FF, rd, RESP_SLVERR); `CHK("unmapped", 32'h0, rd)
    wr(IDX_IRQ_EN, 8'h0C);
    rd_reg(IDX_IRQ_EN, rd); `CHK("irq enable", 32'h0C, rd)
    $display("test registers done");
    // Matches with reset defaults, disabled, disabled with upper source and enabled toggling on the lower source
    wr(IDX_MODE[1], 8'h05);
    wr(IDX_CMP[2], 8'h03);
    wr(IDX_CMP[3], 8'h00);
    for (k = 0; k < 4; k++)
    begin
      if (k > 0) wr(IDX_FFCR[1], CFG[k]);
      wr(IDX_IRQ_CLR, 8'h0F);
      o0 = pairBOutputToggle;
      wr(IDX_RUN[1], 8'h01);
      wait_irq(60, 1'h1);
      `CHK("toggle", TOG[k] ? ~o0 : o0, pairBOutputToggle)
      wr(IDX_RUN[1], 8'h00);
      rd_reg(IDX_IRQ_STAT, rd); `CHK("status", 32'h04, rd)
    end
    $display("test matches done");
    // Compare zero on the upper timer, lower timer masked
    wr(IDX_IRQ_EN, 8'h08);
    wr(IDX_FFCR[1], 8'h0F);
    wr(IDX_IRQ_CLR, 8'h0F);
    o0 = pairBOutputToggle;
    wr(IDX_RUN[1], 8'h03);
    repeat (1900) @(posedge clk_sys);
    `CHK("irq masked", 1'h0, irq)
    rd_reg(IDX_IRQ_STAT, rd); `CHK("status", 32'h04, rd)
    wait_irq(400, 1'h1);
    `CHK("toggle upper", ~o0, pairBOutputToggle)
    wr(IDX_RUN[1], 8'h00);
    wr(IDX_IRQ_CLR, 8'h0F);
    repeat (2) @(posedge clk_sys);
    `CHK("irq cleared", 1'h0, irq)
    $display("test compare zero done");
    // Software commands
    for (k = 0; k < 5; k++)
    begin
      wr(IDX_FFCR[1], {4'h0, CMDS[k], 2'h0});
      repeat (2) @(posedge clk_sys);
      `CHK("out", FFX[k], pairBOutputToggle)
      rd_reg(IDX_STATE, rd); `CHK("state", {30'h0, FFX[k], 1'h0}, rd)
    end
    wr(IDX_FFCR[0], 8'h04);
    repeat (2) @(posedge clk_sys);
    `CHK("out A", 1'h1, pairAOutputToggle)
    $display("test commands done");
    // External count pin on the lower timer, upper timer cascaded on its match
    wr(IDX_RUN[1], 8'h00);
    wr(IDX_MODE[1], 8'h00);
    wr(IDX_CMP[2], 8'h02);
    wr(IDX_CMP[3], 8'h02);
    wr(IDX_IRQ_CLR, 8'h0F);
    wr(IDX_IRQ_EN, 8'h08);
    wr(IDX_RUN[1], 8'h03);
    repeat (4)
    begin
      extB <= 1'h1;
      repeat (3) @(posedge clk_sys);
      extB <= 1'h0;
      repeat (3) @(posedge clk_sys);
    end
    repeat (4) @(posedge clk_sys);
    rd_reg(IDX_IRQ_STAT, rd); `CHK("status", 32'h0C, rd)
    `CHK("irq cascade", 1'h1, irq)
    wr(IDX_RUN[1], 8'h00);
    $display("test external count done");
    report_and_stop();
  end
endmodule : tb_dual_8bit_interval_timer
